// ==== core/mrg_device.sv ====
// Mirror array end: block loaded flags and reset group selection.
// Assumes one clock shared with the controller end via mrg_if.
//
// Summary of operation
// - Fifteen blocks of seventy-two contiguous rows.
// - First and last 64 row bits invisible.
// - Four grouping modes select blocks reset.
// - Single mode: any block, any order.
// - Reset moves loaded data into mirror state.
// - Dual pairs 0-1..12-13, block 14 alone.
// - Dual pairs reset in any order after load.
// - Quad groups 0-3,4-7,8-11,12-14.
// - Quad groups random order after load.
// - Global mode resets all blocks together.
// - Controller loads whole array before global reset.
// - Controller presents four-bit block pointer.
// - Controller drives two-bit grouping mode field.
// - Status high while reset in progress.
`timescale 1ns/100ps
`include "mrg_consts.svh"
module mrg_device #(
  parameter int NUM_BLOCKS   = `MRG_NUM_BLOCKS,
  parameter int RESET_CYCLES = `MRG_RESET_CYCLES
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  mrg_if.device                      link,
  output logic [NUM_BLOCKS-1:0]      block_loaded_out,
  output logic [NUM_BLOCKS-1:0]      block_state_out,
  output logic [NUM_BLOCKS-1:0]      block_pending_bit_out
);
  // ----------------------------------------
  // Pointer and load decode
  // ----------------------------------------
  logic [NUM_BLOCKS-1:0] sel_mask;
  logic                  vis_col;
  logic                  ptr_in_range;
  logic                  mode_global;
  logic                  load_hit;
  logic                  xfer_now;

  // out of range pointer selects nothing except in global mode
  assign ptr_in_range = (link.block_pointer <= `MRG_LAST_BLOCK);
  assign mode_global  = (link.reset_group_mode_sel == mrg_pkg::MRG_MODE_GLOBAL);

  assign vis_col = (link.load_col >= 11'(`MRG_BORDER_BITS)) &&
                   (link.load_col < 11'(`MRG_ROW_BITS + `MRG_BORDER_BITS));

  // row data lands in its block
  assign load_hit = link.load_valid &&
                    (link.load_block <= `MRG_LAST_BLOCK) &&
                    (link.load_row < 7'(`MRG_ROWS_PER_BLOCK)) &&
                    vis_col;

  // ----------------------------------------
  // Reset pulse sequencing
  // ----------------------------------------
  mrg_pkg::mrg_state_t   state_q;
  mrg_pkg::mrg_state_t   state_d;
  logic [7:0]            cnt_q;
  logic [7:0]            cnt_d;
  logic [NUM_BLOCKS-1:0] target_q;
  logic [NUM_BLOCKS-1:0] target_d;
  logic                  active_q;
  logic                  active_d;
  logic [NUM_BLOCKS-1:0] loaded_q;
  logic [NUM_BLOCKS-1:0] pend_q;
  logic [NUM_BLOCKS-1:0] mirror_q;

  // mirrors move in the cycle after the pulse
  assign xfer_now = (state_q == mrg_pkg::MRG_ST_DONE);

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    target_d = target_q;
    case (state_q)
      mrg_pkg::MRG_ST_IDLE: begin
        if (link.reset_req && (sel_mask != '0)) begin
          target_d = sel_mask;
          cnt_d    = 8'(RESET_CYCLES - 1);
          state_d  = mrg_pkg::MRG_ST_PULSE;
        end
      end
      mrg_pkg::MRG_ST_PULSE: begin
        if (cnt_q == 8'h00) begin
          state_d = mrg_pkg::MRG_ST_DONE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = mrg_pkg::MRG_ST_IDLE;
      end
    endcase
    active_d = (state_d != mrg_pkg::MRG_ST_IDLE);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q  <= mrg_pkg::MRG_ST_IDLE;
      cnt_q    <= 8'h00;
      target_q <= '0;
      active_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      target_q <= target_d;
      active_q <= active_d;
    end
  end

  // ----------------------------------------
  // Per block group membership and storage
  // ----------------------------------------
  for (genvar gi = 0; gi < NUM_BLOCKS; gi++) begin : g_block
    logic in_single;
    logic in_dual;
    logic in_quad;
    logic sel_here;
    logic load_here;
    logic xfer_here;
    logic ld_q;
    logic ld_d;
    logic pd_q;
    logic pd_d;
    logic mr_q;
    logic mr_d;

    assign in_single = (link.block_pointer == 4'(gi));
    // pairs 0-1 to 12-13, block 14 alone
    assign in_dual   = (link.block_pointer[3:1] == 3'(gi / 2));
    assign in_quad   = (link.block_pointer[3:2] == 2'(gi / 4));

    always_comb begin
      sel_here = 1'b0;
      if (mode_global) begin
        sel_here = 1'b1;
      end else if (ptr_in_range) begin
        case (link.reset_group_mode_sel)
          mrg_pkg::MRG_MODE_DUAL: sel_here = in_dual;
          mrg_pkg::MRG_MODE_QUAD: sel_here = in_quad;
          default:                sel_here = in_single;
        endcase
      end
    end
    assign sel_mask[gi] = sel_here;

    assign load_here = load_hit && (link.load_block == 4'(gi));
    // a pair moves only loaded blocks
    // a quad moves only loaded blocks
    assign xfer_here = xfer_now && target_q[gi] && ld_q;

    // mirrors keep state until a reset
    always_comb begin
      mr_d = mr_q;
      pd_d = pd_q;
      ld_d = ld_q;
      if (xfer_here) begin
        mr_d = pd_q;
        ld_d = 1'b0;
      end
      // A load in the transfer cycle wins over the clear
      if (load_here) begin
        pd_d = link.load_bit;
        ld_d = 1'b1;
      end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        ld_q <= 1'b0;
        pd_q <= 1'b0;
        mr_q <= 1'b0;
      end else begin
        ld_q <= ld_d;
        pd_q <= pd_d;
        mr_q <= mr_d;
      end
    end

    assign loaded_q[gi] = ld_q;
    assign pend_q[gi]   = pd_q;
    assign mirror_q[gi] = mr_q;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.reset_active     = active_q;
  assign block_loaded_out      = loaded_q;
  assign block_state_out       = mirror_q;
  assign block_pending_bit_out = pend_q;
endmodule

// ==== core/mrg_consts.svh ====
// Constants for the mirror reset group select block.
// Assumes inclusion by bare name from core/ files.
`ifndef MRG_CONSTS_SVH
`define MRG_CONSTS_SVH
`define MRG_NUM_BLOCKS      15
`define MRG_ROWS_PER_BLOCK  72
`define MRG_BORDER_BITS     64
`define MRG_ROW_BITS        1920
`define MRG_LAST_BLOCK      4'hE
`define MRG_RESET_TIME_NS   400
`define MRG_CLK_PERIOD_NS   40
`define MRG_RESET_CYCLES    ((`MRG_RESET_TIME_NS + `MRG_CLK_PERIOD_NS - 1) / `MRG_CLK_PERIOD_NS)
`endif

// ==== core/mrg_pkg.sv ====
// Types for the mirror reset group select block.
// Assumes nothing outside this file.
package mrg_pkg;
  typedef enum logic [1:0] {
    MRG_MODE_SINGLE = 2'h0,
    MRG_MODE_DUAL   = 2'h1,
    MRG_MODE_QUAD   = 2'h2,
    MRG_MODE_GLOBAL = 2'h3
  } mrg_mode_t;
  typedef enum logic [1:0] {
    MRG_ST_IDLE  = 2'h0,
    MRG_ST_PULSE = 2'h1,
    MRG_ST_DONE  = 2'h3
  } mrg_state_t;
endpackage

// ==== core/mrg_if.sv ====
// Link between display controller and mirror array reset logic.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface mrg_if;
  logic                 load_valid;
  logic [3:0]           load_block;
  logic                 load_bit;
  logic [10:0]          load_col;
  logic [6:0]           load_row;
  logic                 reset_req;
  logic [3:0]           block_pointer;
  mrg_pkg::mrg_mode_t   reset_group_mode_sel;
  logic                 reset_active;
  modport device (
    input  load_valid, load_block, load_bit, load_col, load_row,
    input  reset_req, block_pointer, reset_group_mode_sel,
    output reset_active
  );
  modport ctrl (
    output load_valid, load_block, load_bit, load_col, load_row,
    output reset_req, block_pointer, reset_group_mode_sel,
    input  reset_active
  );
endinterface

// ==== core/mrg_ctrl.sv ====
// Controller end: loads a block, then issues a reset command.
// Assumes one clock shared with the device end via mrg_if.
`timescale 1ns/100ps
`include "mrg_consts.svh"
module mrg_ctrl (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  mrg_if.ctrl                      link,
  input  wire logic                cmd_valid_in,
  input  wire logic [3:0]          cmd_pointer_in,
  input  wire mrg_pkg::mrg_mode_t  cmd_mode_in,
  input  wire logic                cmd_bit_in,
  input  wire logic                cmd_load_all_in,
  output logic                     cmd_ready_out,
  output logic                     busy_out
);
  // ----------------------------------------
  // Load then reset sequence
  // ----------------------------------------
  typedef enum logic [1:0] {
    MRG_C_IDLE  = 2'h0,
    MRG_C_LOAD  = 2'h1,
    MRG_C_RST   = 2'h3,
    MRG_C_WAIT  = 2'h2
  } mrg_cstate_t;
  mrg_cstate_t         st_q;
  mrg_cstate_t         st_d;
  logic [3:0]          blk_q;
  logic [3:0]          blk_d;
  logic [3:0]          last_q;
  logic [3:0]          last_d;
  logic [3:0]          ptr_q;
  logic [3:0]          ptr_d;
  mrg_pkg::mrg_mode_t  mode_q;
  mrg_pkg::mrg_mode_t  mode_d;
  logic                bit_q;
  logic                bit_d;
  logic                lv_q;
  logic                lv_d;
  logic                rq_q;
  logic                rq_d;
  logic                rdy_q;
  logic                rdy_d;
  logic                busy_q;
  logic                busy_d;

  always_comb begin
    st_d   = st_q;
    blk_d  = blk_q;
    last_d = last_q;
    ptr_d  = ptr_q;
    mode_d = mode_q;
    bit_d  = bit_q;
    lv_d   = 1'b0;
    rq_d   = 1'b0;
    case (st_q)
      MRG_C_IDLE: begin
        if (cmd_valid_in) begin
          ptr_d  = cmd_pointer_in;
          mode_d = cmd_mode_in;
          bit_d  = cmd_bit_in;
          // global reset loads every block first
          if (cmd_load_all_in || cmd_mode_in == mrg_pkg::MRG_MODE_GLOBAL) begin
            blk_d  = 4'h0;
            last_d = `MRG_LAST_BLOCK;
          end else begin
            blk_d  = cmd_pointer_in;
            last_d = cmd_pointer_in;
          end
          lv_d = 1'b1;
          st_d = MRG_C_LOAD;
        end
      end
      MRG_C_LOAD: begin
        if (blk_q == last_q) begin
          rq_d = 1'b1;
          st_d = MRG_C_RST;
        end else begin
          blk_d = blk_q + 4'h1;
          lv_d  = 1'b1;
        end
      end
      MRG_C_RST: st_d = MRG_C_WAIT;
      default: begin
        if (!link.reset_active) begin
          st_d = MRG_C_IDLE;
        end
      end
    endcase
    rdy_d  = (st_d == MRG_C_IDLE);
    busy_d = (st_d != MRG_C_IDLE);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q   <= MRG_C_IDLE;
      blk_q  <= 4'h0;
      last_q <= 4'h0;
      ptr_q  <= 4'h0;
      mode_q <= mrg_pkg::MRG_MODE_SINGLE;
      bit_q  <= 1'b0;
      lv_q   <= 1'b0;
      rq_q   <= 1'b0;
      rdy_q  <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      blk_q  <= blk_d;
      last_q <= last_d;
      ptr_q  <= ptr_d;
      mode_q <= mode_d;
      bit_q  <= bit_d;
      lv_q   <= lv_d;
      rq_q   <= rq_d;
      rdy_q  <= rdy_d;
      busy_q <= busy_d;
    end
  end

  assign link.block_pointer        = ptr_q;
  assign link.reset_group_mode_sel = mode_q;
  assign link.load_valid           = lv_q;
  assign link.load_block           = blk_q;
  assign link.load_bit             = bit_q;
  assign link.load_col             = 11'(`MRG_BORDER_BITS);
  assign link.load_row             = 7'h00;
  assign link.reset_req            = rq_q;
  assign cmd_ready_out             = rdy_q;
  assign busy_out                  = busy_q;
endmodule

// ==== test/mrg_properties.sv ====
// Checker on the link between the two ends.
// Assumes instantiation beside mrg_if, signals joined by name.
`timescale 1ns/100ps
module mrg_properties #(
  parameter int RESET_CYCLES = 10
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               reset_req,
  input  wire logic [3:0]         block_pointer,
  input  wire mrg_pkg::mrg_mode_t reset_group_mode_sel,
  input  wire logic               reset_active,
  input  wire logic               load_valid
);
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  logic       glob;
  assign glob = reset_group_mode_sel == mrg_pkg::MRG_MODE_GLOBAL;
  // Cycles the pulse has stood so far
  always_comb begin
    hold_d = reset_active ? hold_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) hold_q <= 8'h00;
    else hold_q <= hold_d;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_pulse_start: assert property (reset_req && !reset_active && !$past(reset_active)
    && (block_pointer <= 4'hE || glob) |=> reset_active) else $error("pulse did not start");
  chk_pulse_len: assert property ($fell(reset_active) |-> hold_q == RESET_CYCLES + 1)
    else $error("pulse length wrong");
  chk_pulse_max: assert property (reset_active |-> hold_q < RESET_CYCLES + 1)
    else $error("pulse too long");
  chk_bad_pointer: assert property (reset_req && !reset_active && block_pointer > 4'hE && !glob
    |=> !reset_active) else $error("out of range pointer reset");
  chk_pulse_cause: assert property ($rose(reset_active) |-> $past(reset_req))
    else $error("pulse without request");
  chk_select_held: assert property (reset_active && $past(reset_active)
    |-> $stable(block_pointer) && $stable(reset_group_mode_sel)) else $error("selection moved");
  chk_req_idle: assert property (reset_req |-> !reset_active)
    else $error("request during pulse");
  chk_load_quiet: assert property (load_valid |-> !reset_active)
    else $error("load during pulse");
endmodule

// ==== test/mirror_reset_group_select_tb_top.sv ====
// Bench joining controller end and mirror end over mrg_if.
// Assumes core/ package, interface and both ends compiled first.
`timescale 1ns/100ps
module mirror_reset_group_select_tb_top;
  logic               clk_in;
  logic               rst_in;
  logic               cmd_valid_in;
  logic [3:0]         cmd_pointer_in;
  mrg_pkg::mrg_mode_t cmd_mode_in;
  logic               cmd_bit_in;
  logic               cmd_load_all_in;
  logic               cmd_ready_out;
  logic [14:0]        loaded;
  logic [14:0]        state;
  logic [14:0]        exp_ld;
  logic [14:0]        exp_st;
  logic [14:0]        exp_pd;
  logic [14:0]        q_ld[$];
  logic [14:0]        q_st[$];
  logic [14:0]        q_pd[$];
  logic [14:0]        pend;
  logic               busy;
  logic [31:0]        rnd;
  logic               rdy_q;
  int                 errors;
  int                 samples_checked;
  int                 seed;
  mrg_if i_mrg_if ();
  mrg_device #(.NUM_BLOCKS(15), .RESET_CYCLES(10)) i_mrg_device (.clk_in(clk_in), .rst_in(rst_in),
    .link(i_mrg_if), .block_loaded_out(loaded), .block_state_out(state), .block_pending_bit_out(pend));
  mrg_ctrl i_mrg_ctrl (.clk_in(clk_in), .rst_in(rst_in), .link(i_mrg_if), .cmd_valid_in(cmd_valid_in),
    .cmd_pointer_in(cmd_pointer_in), .cmd_mode_in(cmd_mode_in), .cmd_bit_in(cmd_bit_in),
    .cmd_load_all_in(cmd_load_all_in), .cmd_ready_out(cmd_ready_out), .busy_out(busy));
  mrg_properties #(.RESET_CYCLES(10)) i_mrg_properties (.clk_in(clk_in), .rst_in(rst_in),
    .reset_req(i_mrg_if.reset_req), .block_pointer(i_mrg_if.block_pointer),
    .reset_group_mode_sel(i_mrg_if.reset_group_mode_sel), .reset_active(i_mrg_if.reset_active),
    .load_valid(i_mrg_if.load_valid));
  always #20 clk_in = ~clk_in;
  task automatic cmp(string name, logic [14:0] exp, logic [14:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (cmd_ready_out !== 1'b1) begin
      errors++;
      results();
    end
  endtask
  // Issue one command and note the block states it must leave
  task automatic send(logic [1:0] m, logic [3:0] p, logic b, logic all);
    logic g;
    logic la;
    wait_ready();
    // Global mode makes the controller load the whole array
    la = all || m == 2'h3;
    if (la) exp_ld = 15'h7FFF;
    else if (p <= 4'hE) exp_ld[p] = 1'b1;
    for (int i = 0; i < 15; i++) begin
      if (la || i == p) exp_pd[i] = b;
      g = m == 2'h3 || (p <= 4'hE && (m == 2'h0 ? i == p : (m == 2'h1 ? i / 2 == p / 2 : i / 4 == p / 4)));
      if (g && exp_ld[i]) begin
        exp_st[i] = exp_pd[i];
        exp_ld[i] = 1'b0;
      end
    end
    cmd_mode_in = mrg_pkg::mrg_mode_t'(m);
    cmd_pointer_in = p;
    cmd_bit_in = b;
    cmd_load_all_in = all;
    cmd_valid_in = 1'b1;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    q_ld.push_back(exp_ld);
    q_st.push_back(exp_st);
    q_pd.push_back(exp_pd);
  endtask
  // Result shows when the controller returns to ready
  always @(negedge clk_in) begin
    if (cmd_ready_out === 1'b1 && rdy_q !== 1'b1 && q_st.size() > 0) begin
      cmp("state", q_st.pop_front(), state);
      cmp("loaded", q_ld.pop_front(), loaded);
      cmp("pending", q_pd.pop_front(), pend);
    end
    if (rst_in === 1'b0) cmp("busy", {14'h0000, ~cmd_ready_out}, {14'h0000, busy});
    rdy_q <= cmd_ready_out;
  end
  initial begin
    seed = 32'hE54D;
    errors = 0;
    samples_checked = 0;
    {clk_in, rdy_q, cmd_valid_in, cmd_bit_in, cmd_load_all_in} = 5'h00;
    rst_in = 1'b1;
    cmd_pointer_in = 4'h0;
    cmd_mode_in = mrg_pkg::MRG_MODE_SINGLE;
    {exp_ld, exp_st, exp_pd} = 45'h0;
    repeat (20) @(negedge clk_in);
    rst_in = 1'b0;
    // Every mode at block 13, inside quad group 12-14, then a pointer past the end
    for (int m = 0; m < 4; m++) begin
      send(m[1:0], 4'hD, m[0], 1'b1);
      send(m[1:0], 4'hF, !m[0], 1'b0);
    end
    repeat (60) begin
      rnd = $random(seed);
      send(rnd[1:0], rnd[5:2], rnd[6], rnd[8:7] == 2'h0);
    end
    wait_ready();
    repeat (2) @(negedge clk_in);
    cmp("queue", 15'h0000, 15'(q_st.size()));
    results();
  end
endmodule
